//--- tpw_pkg.sv
// constants and types shared by the timer, prescaler and watchdog unit
package tpw_pkg;

    // ------------------------------------------------------------------
    // register byte addresses
    // ------------------------------------------------------------------
    localparam logic [31:0] ADDR_WDOG_COUNT   = 32'h8000004c;
    localparam logic [31:0] ADDR_TIMER_COUNT  = 32'h80000050;
    localparam logic [31:0] ADDR_TIMER_RELOAD = 32'h80000054;
    localparam logic [31:0] ADDR_TIMER_CTRL   = 32'h80000058;
    localparam logic [31:0] ADDR_PSC_COUNT    = 32'h80000060;
    localparam logic [31:0] ADDR_PSC_RELOAD   = 32'h80000064;
    localparam logic [31:0] ADDR_IRQ_STATUS   = 32'h80000068;
    localparam logic [31:0] ADDR_IRQ_MASK     = 32'h8000006c;

    // ------------------------------------------------------------------
    // field positions and widths
    // ------------------------------------------------------------------
    localparam int CTRL_ENABLE_BIT      = 0;
    localparam int CTRL_AUTO_RELOAD_BIT = 1;
    localparam int CTRL_FORCE_LOAD_BIT  = 2;
    localparam int PSC_W                = 10;
    localparam int EVT_TIMER_BIT        = 0;
    localparam int EVT_WDOG_BIT         = 1;
    localparam int EVT_W                = 2;

    // ------------------------------------------------------------------
    // reset values and special division reloads
    // ------------------------------------------------------------------
    localparam logic [31:0]      WDOG_RESET    = 32'hffffffff;
    localparam logic [31:0]      TIMER_RESET   = 32'h00000000;
    localparam logic [PSC_W-1:0] PSC_RESET     = 10'h000;
    localparam logic [PSC_W-1:0] PSC_ONE       = 10'h001;
    localparam logic [PSC_W-1:0] PSC_TWO       = 10'h002;
    localparam logic [PSC_W-1:0] PSC_EFF_DIV4  = 10'h003;
    localparam logic [PSC_W-1:0] PSC_EFF_DIV6  = 10'h005;
    localparam logic [31:0]      ZERO32        = 32'h00000000;
    localparam logic [31:0]      ONE32         = 32'h00000001;
    localparam logic [EVT_W-1:0] EVT_NONE      = 2'h0;

    // ------------------------------------------------------------------
    // register bus request
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } tpw_req_t;

    // timer run state
    typedef enum logic [0:0] {
        TMR_IDLE,
        TMR_RUN
    } tpw_tmr_state_t;

endpackage : tpw_pkg

//--- tpw_timer_unit.sv
// prescaler, second general purpose timer and watchdog counter with register port
//
// Local design decision: strobed register access.
`timescale 1ns/10ps

module tpw_timer_unit (
    input  wire logic             clk_sys,       // system clock, 10 MHz
    input  wire logic             resetn,        // asynchronous reset, active low
    input  wire tpw_pkg::tpw_req_t req,          // register request
    output logic [31:0]           rdata,         // read data, cycle after read strobe
    output logic                  irq,           // level interrupt, unmasked status set
    output logic                  timer_event,   // one-cycle pulse on timer underflow
    output logic                  wdog_expired   // level, watchdog reached underflow
);

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [tpw_pkg::PSC_W-1:0] eff_reload(
        input logic [tpw_pkg::PSC_W-1:0] rv);
        logic [tpw_pkg::PSC_W-1:0] e;
        e = rv;
        if (rv == tpw_pkg::PSC_RESET || rv == tpw_pkg::PSC_ONE) begin
            e = tpw_pkg::PSC_EFF_DIV4;
        end else if (rv == tpw_pkg::PSC_TWO) begin
            e = tpw_pkg::PSC_EFF_DIV6;
        end
        return e;
    endfunction : eff_reload

    function automatic logic hit(
        input tpw_pkg::tpw_req_t r,
        input logic [31:0]       a);
        return r.wr && (r.addr == a);
    endfunction : hit

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [tpw_pkg::PSC_W-1:0] psc_cnt_q,  psc_cnt_d;
    logic [tpw_pkg::PSC_W-1:0] psc_rld_q,  psc_rld_d;
    logic [31:0]               tmr_cnt_q,  tmr_cnt_d;
    logic [31:0]               tmr_rld_q,  tmr_rld_d;
    logic                      tmr_rl_q,   tmr_rl_d;
    tpw_pkg::tpw_tmr_state_t   tmr_st_q,   tmr_st_d;
    logic [31:0]               wdg_cnt_q,  wdg_cnt_d;
    logic                      wdg_exp_q,  wdg_exp_d;
    logic [tpw_pkg::EVT_W-1:0] sts_q,      sts_d;
    logic [tpw_pkg::EVT_W-1:0] msk_q,      msk_d;
    logic [31:0]               rdata_q,    rdata_d;
    logic                      tev_q;

    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    wire wr_wdg   = hit(req, tpw_pkg::ADDR_WDOG_COUNT);
    wire wr_trld  = hit(req, tpw_pkg::ADDR_TIMER_RELOAD);
    wire wr_tctl  = hit(req, tpw_pkg::ADDR_TIMER_CTRL);
    wire wr_pcnt  = hit(req, tpw_pkg::ADDR_PSC_COUNT);
    wire wr_prld  = hit(req, tpw_pkg::ADDR_PSC_RELOAD);
    wire wr_sts   = hit(req, tpw_pkg::ADDR_IRQ_STATUS);
    wire wr_msk   = hit(req, tpw_pkg::ADDR_IRQ_MASK);
    wire force_ld = wr_tctl && req.wdata[tpw_pkg::CTRL_FORCE_LOAD_BIT];
    wire ctl_en   = req.wdata[tpw_pkg::CTRL_ENABLE_BIT];
    wire tmr_en   = (tmr_st_q == tpw_pkg::TMR_RUN);

    // ------------------------------------------------------------------
    // prescaler
    // ------------------------------------------------------------------
    // a tick marks the end of each counter cycle
    wire tick = (psc_cnt_q == tpw_pkg::PSC_RESET) && !wr_pcnt;

    // small reloads stretched to divide by four or six
    wire [tpw_pkg::PSC_W-1:0] psc_eff = eff_reload(psc_rld_q);

    always_comb begin
        psc_cnt_d = psc_cnt_q - tpw_pkg::PSC_ONE;
        if (wr_pcnt) begin
            psc_cnt_d = req.wdata[tpw_pkg::PSC_W-1:0];
        end else if (tick) begin
            psc_cnt_d = psc_eff;
        end
        psc_rld_d = wr_prld ? req.wdata[tpw_pkg::PSC_W-1:0] : psc_rld_q;
    end

    // ------------------------------------------------------------------
    // timer two
    // ------------------------------------------------------------------
    wire tmr_under = tick && tmr_en && (tmr_cnt_q == tpw_pkg::ZERO32);

    always_comb begin
        tmr_cnt_d = tmr_cnt_q;
        tmr_st_d  = tmr_st_q;
        tmr_rl_d  = tmr_rl_q;
        tmr_rld_d = wr_trld ? req.wdata : tmr_rld_q;
        case (tmr_st_q)
            tpw_pkg::TMR_IDLE: begin
                tmr_st_d = tpw_pkg::TMR_IDLE;
            end
            tpw_pkg::TMR_RUN: begin
                if (tick && tmr_cnt_q != tpw_pkg::ZERO32) begin
                    tmr_cnt_d = tmr_cnt_q - tpw_pkg::ONE32;
                end else if (tmr_under) begin
                    if (tmr_rl_q) begin
                        tmr_cnt_d = tmr_rld_q;
                    end else begin
                        tmr_st_d = tpw_pkg::TMR_IDLE;
                    end
                end
            end
            default: begin
                tmr_st_d = tpw_pkg::TMR_IDLE;
            end
        endcase
        if (wr_tctl) begin
            tmr_rl_d = req.wdata[tpw_pkg::CTRL_AUTO_RELOAD_BIT];
            // enable bit starts or halts counting
            tmr_st_d = ctl_en ? tpw_pkg::TMR_RUN : tpw_pkg::TMR_IDLE;
        end
        if (force_ld) begin
            tmr_cnt_d = tmr_rld_q;
        end
    end

    // ------------------------------------------------------------------
    // watchdog
    // ------------------------------------------------------------------
    wire wdg_under = tick && !wdg_exp_q && (wdg_cnt_q == tpw_pkg::ZERO32) && !wr_wdg;

    always_comb begin
        wdg_cnt_d = wdg_cnt_q;
        wdg_exp_d = wdg_exp_q || wdg_under;
        if (wr_wdg) begin
            wdg_cnt_d = req.wdata;
            wdg_exp_d = 1'b0;
        end else if (tick && !wdg_exp_q && wdg_cnt_q != tpw_pkg::ZERO32) begin
            wdg_cnt_d = wdg_cnt_q - tpw_pkg::ONE32;
        end
    end

    // ------------------------------------------------------------------
    // interrupt status and mask
    // ------------------------------------------------------------------
    wire [tpw_pkg::EVT_W-1:0] evt_set = {wdg_under, tmr_under};
    wire [tpw_pkg::EVT_W-1:0] evt_clr = wr_sts ? req.wdata[tpw_pkg::EVT_W-1:0] : tpw_pkg::EVT_NONE;

    // set wins over a clear in the same cycle
    assign sts_d = (sts_q & ~evt_clr) | evt_set;
    assign msk_d = wr_msk ? req.wdata[tpw_pkg::EVT_W-1:0] : msk_q;

    // ------------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------------
    always_comb begin
        rdata_d = tpw_pkg::ZERO32;
        if (req.rd) begin
            case (req.addr)
                tpw_pkg::ADDR_WDOG_COUNT:   rdata_d = wdg_cnt_q;
                tpw_pkg::ADDR_TIMER_COUNT:  rdata_d = tmr_cnt_q;
                tpw_pkg::ADDR_TIMER_RELOAD: rdata_d = tmr_rld_q;
                tpw_pkg::ADDR_TIMER_CTRL: begin
                    rdata_d[tpw_pkg::CTRL_ENABLE_BIT]      = tmr_en;
                    rdata_d[tpw_pkg::CTRL_AUTO_RELOAD_BIT] = tmr_rl_q;
                end
                tpw_pkg::ADDR_PSC_COUNT:    rdata_d[tpw_pkg::PSC_W-1:0] = psc_cnt_q;
                tpw_pkg::ADDR_PSC_RELOAD:   rdata_d[tpw_pkg::PSC_W-1:0] = psc_rld_q;
                tpw_pkg::ADDR_IRQ_STATUS:   rdata_d[tpw_pkg::EVT_W-1:0] = sts_q;
                tpw_pkg::ADDR_IRQ_MASK:     rdata_d[tpw_pkg::EVT_W-1:0] = msk_q;
                default:                    rdata_d = tpw_pkg::ZERO32;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            psc_cnt_q <= tpw_pkg::PSC_RESET;
            psc_rld_q <= tpw_pkg::PSC_RESET;
            tmr_cnt_q <= tpw_pkg::TIMER_RESET;
            tmr_rld_q <= tpw_pkg::TIMER_RESET;
            tmr_rl_q  <= 1'b0;
            tmr_st_q  <= tpw_pkg::TMR_IDLE;
            wdg_cnt_q <= tpw_pkg::WDOG_RESET;
            wdg_exp_q <= 1'b0;
            sts_q     <= tpw_pkg::EVT_NONE;
            msk_q     <= tpw_pkg::EVT_NONE;
            rdata_q   <= tpw_pkg::ZERO32;
            tev_q     <= 1'b0;
        end else begin
            psc_cnt_q <= psc_cnt_d;
            psc_rld_q <= psc_rld_d;
            tmr_cnt_q <= tmr_cnt_d;
            tmr_rld_q <= tmr_rld_d;
            tmr_rl_q  <= tmr_rl_d;
            tmr_st_q  <= tmr_st_d;
            wdg_cnt_q <= wdg_cnt_d;
            wdg_exp_q <= wdg_exp_d;
            sts_q     <= sts_d;
            msk_q     <= msk_d;
            rdata_q   <= rdata_d;
            tev_q     <= tmr_under;
        end
    end

    assign rdata        = rdata_q;
    assign irq          = |(sts_q & msk_q);
    assign timer_event  = tev_q;
    assign wdog_expired = wdg_exp_q;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    property p_wdog_write;
        @(posedge clk_sys) disable iff (!resetn)
        wr_wdg |=> (wdg_cnt_q == $past(req.wdata));
    endproperty
    a_wdog_write: assert property (p_wdog_write) else $error("watchdog write not taken");

    property p_wdog_read;
        @(posedge clk_sys) disable iff (!resetn)
        (req.rd && req.addr == tpw_pkg::ADDR_WDOG_COUNT) |=> (rdata == $past(wdg_cnt_q));
    endproperty
    a_wdog_read: assert property (p_wdog_read) else $error("watchdog read wrong");

    property p_tmr_read;
        @(posedge clk_sys) disable iff (!resetn)
        (req.rd && req.addr == tpw_pkg::ADDR_TIMER_COUNT) |=> (rdata == $past(tmr_cnt_q));
    endproperty
    a_tmr_read: assert property (p_tmr_read) else $error("timer count read wrong");

    sequence s_rld_write;
        wr_trld ##1 (!wr_trld && force_ld);
    endsequence
    property p_rld_used;
        @(posedge clk_sys) disable iff (!resetn)
        s_rld_write |=> (tmr_cnt_q == $past(req.wdata, 2));
    endproperty
    a_rld_used: assert property (p_rld_used) else $error("reload value not used");

    property p_force_load;
        @(posedge clk_sys) disable iff (!resetn)
        force_ld ##1 (req.rd && req.addr == tpw_pkg::ADDR_TIMER_CTRL)
            |=> (rdata[tpw_pkg::CTRL_FORCE_LOAD_BIT] == 1'b0);
    endproperty
    a_force_load: assert property (p_force_load) else $error("load bit read as one");

    property p_auto_reload;
        @(posedge clk_sys) disable iff (!resetn)
        (tmr_under && !wr_tctl && !force_ld)
            |=> (tmr_rl_q ? (tmr_cnt_q == $past(tmr_rld_q)) : !tmr_en);
    endproperty
    a_auto_reload: assert property (p_auto_reload) else $error("underflow handling wrong");

    property p_halted;
        @(posedge clk_sys) disable iff (!resetn)
        (!tmr_en && !force_ld) |=> $stable(tmr_cnt_q);
    endproperty
    a_halted: assert property (p_halted) else $error("disabled timer moved");

    property p_psc_read;
        @(posedge clk_sys) disable iff (!resetn)
        (req.rd && req.addr == tpw_pkg::ADDR_PSC_COUNT)
            |=> (rdata == {22'h000000, $past(psc_cnt_q)});
    endproperty
    a_psc_read: assert property (p_psc_read) else $error("prescaler read wrong");

    property p_psc_rld;
        @(posedge clk_sys) disable iff (!resetn)
        wr_prld ##1 (req.rd && req.addr == tpw_pkg::ADDR_PSC_RELOAD && !wr_prld)
            |=> (rdata == {22'h000000, $past(req.wdata[9:0], 2)});
    endproperty
    a_psc_rld: assert property (p_psc_rld) else $error("prescaler reload readback wrong");

    property p_div;
        @(posedge clk_sys) disable iff (!resetn)
        (tick && !wr_prld) |=> (psc_cnt_q == $past(psc_eff));
    endproperty
    a_div: assert property (p_div) else $error("prescaler reload wrong");

    property p_div_small;
        @(posedge clk_sys) disable iff (!resetn)
        (psc_rld_q <= tpw_pkg::PSC_TWO) |-> (psc_eff >= tpw_pkg::PSC_EFF_DIV4);
    endproperty
    a_div_small: assert property (p_div_small) else $error("small divider not stretched");

    property p_decrement;
        @(posedge clk_sys) disable iff (!resetn)
        (tick && tmr_en && tmr_cnt_q != tpw_pkg::ZERO32 && !force_ld)
            |=> (tmr_cnt_q == $past(tmr_cnt_q) - tpw_pkg::ONE32);
    endproperty
    a_decrement: assert property (p_decrement) else $error("timer did not decrement");

    property p_wdog_expire;
        @(posedge clk_sys) disable iff (!resetn)
        wdg_under |=> (wdg_exp_q && sts_q[tpw_pkg::EVT_WDOG_BIT]);
    endproperty
    a_wdog_expire: assert property (p_wdog_expire) else $error("expiry not flagged");

    property p_tmr_event;
        @(posedge clk_sys) disable iff (!resetn)
        tmr_under |=> (timer_event && sts_q[tpw_pkg::EVT_TIMER_BIT]);
    endproperty
    a_tmr_event: assert property (p_tmr_event) else $error("timer event missing");

    property p_wdog_hold;
        @(posedge clk_sys) disable iff (!resetn)
        (wdg_exp_q && !wr_wdg) |=> $stable(wdg_cnt_q);
    endproperty
    a_wdog_hold: assert property (p_wdog_hold) else $error("expired watchdog moved");

    property p_ctrl_read;
        @(posedge clk_sys) disable iff (!resetn)
        (req.rd && req.addr == tpw_pkg::ADDR_TIMER_CTRL)
            |=> (rdata[tpw_pkg::CTRL_FORCE_LOAD_BIT] == 1'b0);
    endproperty
    a_ctrl_read: assert property (p_ctrl_read) else $error("load bit not zero");

endmodule : tpw_timer_unit

//--- tpw_timer_unit_test.sv
// self-checking bench for the prescaler, second timer and watchdog unit
`timescale 1ns/10ps
module tpw_timer_unit_test;

    // ------------------------------------------------------------------
    // signals
    // ------------------------------------------------------------------
    logic              clk_sys;
    logic              resetn;
    tpw_pkg::tpw_req_t req;
    logic [31:0]       rdata;
    logic              irq;
    logic              timer_event;
    logic              wdog_expired;
    int                fail_count;
    int                compares;
    int                ev_count;
    int                e0;
    logic [31:0]       v1;
    logic [31:0]       v2;
    logic [31:0]       rnd;
    logic [9:0]        rv_tab [6];

    tpw_timer_unit dut (
        .clk_sys      (clk_sys),
        .resetn       (resetn),
        .req          (req),
        .rdata        (rdata),
        .irq          (irq),
        .timer_event  (timer_event),
        .wdog_expired (wdog_expired)
    );

    initial clk_sys = 1'b0;
    always #50 clk_sys = ~clk_sys;

    // counts timer pulses for the reload and single-shot windows
    always @(posedge clk_sys) begin
        if (timer_event === 1'b1) ev_count++;
    end

    // ------------------------------------------------------------------
    // tasks and expectations
    // ------------------------------------------------------------------
    task automatic test_done;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : test_done

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_word

    task automatic chk_flag(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_flag

    task automatic bus_wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        req.wr    <= 1'b1;
        req.addr  <= a;
        req.wdata <= d;
        @(posedge clk_sys);
        req.wr    <= 1'b0;
        // let the write settle before any flag is looked at
        #1;
    endtask : bus_wr

    // read data stand only in the cycle after the strobe
    task automatic bus_rd(input logic [31:0] a, output logic [31:0] v);
        @(posedge clk_sys);
        req.rd   <= 1'b1;
        req.addr <= a;
        @(posedge clk_sys);
        req.rd   <= 1'b0;
        #1;
        v = rdata;
    endtask : bus_rd

    // reload and count both written so the tick phase is known
    task automatic set_psc(input logic [9:0] rv);
        bus_wr(tpw_pkg::ADDR_PSC_RELOAD, {22'($urandom), rv});
        bus_wr(tpw_pkg::ADDR_PSC_COUNT, {22'h0, rv});
    endtask : set_psc

    function automatic int psc_period(input logic [9:0] rv);
        if (rv <= 10'h001) return 4;
        if (rv == 10'h002) return 6;
        return int'(rv) + 1;
    endfunction : psc_period

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        req    = '0;
        resetn = 1'b0;
        rnd    = $urandom(32'h9e7e);
        repeat (16) @(posedge clk_sys);
        resetn <= 1'b1;
        bus_rd(tpw_pkg::ADDR_PSC_RELOAD, v1);
        chk_word(v1, 32'h00000000);
        bus_rd(tpw_pkg::ADDR_PSC_COUNT, v1);
        chk_flag(v1 <= 32'h00000003, 1'b1);

        // division rates, watchdog used as tick counter
        rv_tab = '{10'h000, 10'h001, 10'h002, 10'h003, 10'h3ff, 10'h000};
        rv_tab[5] = 10'($urandom_range(60, 4));
        foreach (rv_tab[i]) begin
            set_psc(rv_tab[i]);
            bus_rd(tpw_pkg::ADDR_PSC_RELOAD, v1);
            chk_word(v1, {22'h0, rv_tab[i]});
            bus_wr(tpw_pkg::ADDR_WDOG_COUNT, 32'hffff0000);
            bus_rd(tpw_pkg::ADDR_WDOG_COUNT, v1);
            repeat (5 * psc_period(rv_tab[i]) - 2) @(posedge clk_sys);
            bus_rd(tpw_pkg::ADDR_WDOG_COUNT, v2);
            chk_word(v1 - v2, 32'h00000005);
            bus_rd(tpw_pkg::ADDR_PSC_COUNT, v1);
            chk_flag(v1 <= 32'(psc_period(rv_tab[i]) - 1), 1'b1);
        end

        // watchdog write, expiry and interrupt
        set_psc(10'h064);
        bus_wr(tpw_pkg::ADDR_WDOG_COUNT, rnd);
        bus_rd(tpw_pkg::ADDR_WDOG_COUNT, v1);
        chk_word(v1, rnd);
        set_psc(10'h000);
        bus_wr(tpw_pkg::ADDR_IRQ_MASK, 32'h00000000);
        bus_wr(tpw_pkg::ADDR_WDOG_COUNT, 32'h00000003);
        chk_flag(wdog_expired, 1'b0);
        for (int i = 0; i < 40 && wdog_expired !== 1'b1; i++) @(posedge clk_sys);
        chk_flag(wdog_expired, 1'b1);
        bus_rd(tpw_pkg::ADDR_IRQ_STATUS, v1);
        chk_word(v1 & 32'h00000002, 32'h00000002);
        chk_flag(irq, 1'b0);
        bus_wr(tpw_pkg::ADDR_IRQ_MASK, 32'h00000002);
        chk_flag(irq, 1'b1);
        bus_wr(tpw_pkg::ADDR_WDOG_COUNT, 32'hffff0000);
        chk_flag(wdog_expired, 1'b0);
        bus_wr(tpw_pkg::ADDR_IRQ_STATUS, 32'h00000002);
        chk_flag(irq, 1'b0);

        // timer reload, force load, read-only count, enable
        rnd = $urandom | 32'h00001000;
        bus_wr(tpw_pkg::ADDR_TIMER_RELOAD, rnd);
        bus_rd(tpw_pkg::ADDR_TIMER_RELOAD, v1);
        chk_word(v1, rnd);
        bus_wr(tpw_pkg::ADDR_TIMER_CTRL, 32'h00000004);
        bus_rd(tpw_pkg::ADDR_TIMER_COUNT, v1);
        chk_word(v1, rnd);
        bus_rd(tpw_pkg::ADDR_TIMER_CTRL, v1);
        chk_word(v1, 32'h00000000);
        bus_wr(tpw_pkg::ADDR_TIMER_COUNT, 32'h00000005);
        repeat (40) @(posedge clk_sys);
        bus_rd(tpw_pkg::ADDR_TIMER_COUNT, v1);
        chk_word(v1, rnd);
        bus_wr(tpw_pkg::ADDR_TIMER_CTRL, 32'h00000007);
        bus_rd(tpw_pkg::ADDR_TIMER_COUNT, v1);
        repeat (38) @(posedge clk_sys);
        bus_rd(tpw_pkg::ADDR_TIMER_COUNT, v2);
        chk_word(v1 - v2, 32'h0000000a);

        // auto reload: underflow every three ticks
        bus_wr(tpw_pkg::ADDR_IRQ_MASK, 32'h00000001);
        bus_wr(tpw_pkg::ADDR_TIMER_RELOAD, 32'h00000002);
        bus_wr(tpw_pkg::ADDR_TIMER_CTRL, 32'h00000007);
        repeat (4) @(posedge clk_sys);
        e0 = ev_count;
        repeat (36) @(posedge clk_sys);
        chk_word(32'(ev_count - e0), 32'h00000003);
        chk_flag(irq, 1'b1);
        bus_rd(tpw_pkg::ADDR_TIMER_CTRL, v1);
        chk_word(v1, 32'h00000003);

        // single shot: one underflow then stop
        bus_wr(tpw_pkg::ADDR_TIMER_CTRL, 32'h00000005);
        e0 = ev_count;
        repeat (40) @(posedge clk_sys);
        chk_word(32'(ev_count - e0), 32'h00000001);
        bus_rd(tpw_pkg::ADDR_TIMER_CTRL, v1);
        chk_word(v1, 32'h00000000);
        bus_rd(tpw_pkg::ADDR_TIMER_COUNT, v1);
        chk_word(v1, 32'h00000000);
        bus_wr(tpw_pkg::ADDR_IRQ_STATUS, 32'h00000003);
        chk_flag(irq, 1'b0);

        // unmapped place reads zero
        bus_wr(32'h80000070, rnd);
        bus_rd(32'h80000070, v1);
        chk_word(v1, 32'h00000000);
        test_done;
    end

    // hang guard, well beyond the longest division run
    initial begin
        repeat (60000) @(posedge clk_sys);
        fail_count++;
        test_done;
    end

endmodule : tpw_timer_unit_test
